// ==== include/hsms_pkg.sv ====
// constants and types of the hall sensor measure sequencer
// assumes a 50 MHz system clock and a separate serial-clock domain

package hsms_pkg;

  // ----------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------
  localparam int CLK_NS = 20;
  localparam int POR_NS = 2000;
  localparam int BIAS_NS = 1000;
  localparam int OSC_NS = 2000;
  localparam int HALL_NS = 500;
  localparam int INT_NS = 1000;
  localparam int POR_CYC = (POR_NS + CLK_NS - 1) / CLK_NS;
  localparam int BIAS_CYC = (BIAS_NS + CLK_NS - 1) / CLK_NS;
  localparam int OSC_CYC = (OSC_NS + CLK_NS - 1) / CLK_NS;
  localparam int HALL_CYC = (HALL_NS + CLK_NS - 1) / CLK_NS;
  localparam int INT_CYC = (INT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] POR_LOAD = 8'(POR_CYC - 1);
  localparam logic [7:0] BIAS_LOAD = 8'(BIAS_CYC - 1);
  localparam logic [7:0] OSC_LOAD = 8'(OSC_CYC - 1);
  localparam logic [7:0] HALL_LOAD = 8'(HALL_CYC - 1);
  localparam logic [7:0] INT_LOAD = 8'(INT_CYC - 1);

  // ----------------------------------------------------------
  // bus addresses and framing
  // ----------------------------------------------------------
  localparam logic [7:0] ADDR_WR = 8'h6A;
  localparam logic [7:0] ADDR_RD = 8'h6B;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [2:0] RD_LAST = 3'h5;

  // ----------------------------------------------------------
  // configuration byte
  // ----------------------------------------------------------
  localparam int CFG_TEMP_BIT = 0;
  localparam int CFG_FIELD_BIT = 1;
  localparam int CFG_CONT_BIT = 2;
  localparam logic [7:0] CFG_RST = 8'h03;

  // ----------------------------------------------------------
  // channels and states
  // ----------------------------------------------------------
  localparam logic [1:0] CH_X = 2'h0;
  localparam logic [1:0] CH_Y = 2'h1;
  localparam logic [1:0] CH_Z = 2'h2;
  localparam logic [1:0] CH_T = 2'h3;

  typedef enum logic [8:0] {
    SQ_POR = 9'h001,
    SQ_LOWPWR = 9'h002,
    SQ_BIAS = 9'h004,
    SQ_RESCHK = 9'h008,
    SQ_OSC = 9'h010,
    SQ_HALL = 9'h020,
    SQ_CONV = 9'h040,
    SQ_DONE = 9'h080,
    SQ_HALT = 9'h100
  } hsms_seq_type;

  typedef enum logic [3:0] {
    LK_ADDR = 4'h1,
    LK_WRITE = 4'h2,
    LK_READ = 4'h4,
    LK_IGN = 4'h8
  } hsms_lphase_type;

  typedef struct packed {
    logic [11:0] x;
    logic [11:0] y;
    logic [11:0] z;
    logic [9:0] t;
  } hsms_res_type;

endpackage

// ==== design/hsms_top.sv ====
// hall sensor measure sequencer: serial slave and measurement control
// assumes converter handshake on the system clock, serial clock on sclClk
//
// What this block does
// R01: device answers only as a slave on the two-wire bus, never masters it.
// R02: after start-up the sequencer rests in low power, config accepted.
// R03: each reconfiguration runs bias, restart check, oscillator, hall bias, convert.
// R04: x, y, z converted one after another through one mux, on by default.
// R05: temperature conversion follows x, y, z when enabled; enabled by default.
// R06: low supply stalls the sequencer; recovery starts the sequence again.
// R07: a restart in mid-sequence drops the work and starts from the beginning.
// R08: each finished measurement cycle is signalled on the open-drain interrupt.
// R09: bus address byte is 6A for write and 6B for read.
// R10: data line only pulled low by the device; serial clock is input only.
// R11: field results are 12 bits each, temperature result 10 bits.
// R12: a write transaction from the host triggers a measurement.
// R13: own power-on reset timing, own start-up sequence.
// R14: host may leave the interrupt unconnected but should watch it.
// R15: host issues the bus reset after power-up and after brownouts.
// R16: interrupt is active low, a finite pulse of fixed width.
// R17: reads return only the latest complete set, never a mix of cycles.

module hsms_top (
  input wire logic clock,
  input wire logic rst,
  input wire logic sclClk,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic intOe,
  input wire logic supplyOk,
  input wire logic [11:0] adcData,
  input wire logic adcDone,
  output logic biasEn,
  output logic fastOscEn,
  output logic hallBiasEn,
  output logic [1:0] muxSel,
  output logic adcStart
);

  // ----------------------------------------------------------
  // state types
  // ----------------------------------------------------------
  typedef struct packed {
    logic [2:0] sclS;
    logic [2:0] sdaS;
    logic [2:0] supS;
    logic sclF;
    logic sdaF;
    logic supF;
    logic frameRst;
    logic armRel;
    logic [7:0] cfg;
    logic req;
    hsms_pkg::hsms_seq_type seq;
    logic [7:0] cnt;
    logic [1:0] ch;
    logic adcGo;
    logic biasEn;
    logic oscEn;
    logic hallEn;
    hsms_pkg::hsms_res_type work;
    hsms_pkg::hsms_res_type latest;
    hsms_pkg::hsms_res_type shown;
    logic pending;
    logic intOe;
    logic [7:0] intCnt;
    logic sdaOut;
  } hsms_sys_type;

  typedef struct packed {
    logic [3:0] bitCnt;
    logic [7:0] shift;
    hsms_pkg::hsms_lphase_type phase;
    logic [2:0] byteIdx;
    logic [7:0] tx;
    logic drive;
    logic [7:0] wrByte;
    logic wrSeen;
  } hsms_link_type;

  localparam hsms_sys_type SYS_RST = '{
    sclS: 3'h7, sdaS: 3'h7, supS: 3'h0,
    sclF: 1'b1, sdaF: 1'b1, supF: 1'b0,
    frameRst: 1'b1, armRel: 1'b0,
    cfg: hsms_pkg::CFG_RST, req: 1'b0,
    seq: hsms_pkg::SQ_POR, cnt: hsms_pkg::POR_LOAD,
    ch: hsms_pkg::CH_X, adcGo: 1'b0,
    biasEn: 1'b1, oscEn: 1'b1, hallEn: 1'b0,
    work: '0, latest: '0, shown: '0,
    pending: 1'b0, intOe: 1'b0, intCnt: 8'h00,
    sdaOut: 1'b0
  };

  localparam hsms_link_type LINK_RST = '{
    bitCnt: 4'h0, shift: 8'h00,
    phase: hsms_pkg::LK_ADDR, byteIdx: 3'h0,
    tx: 8'h00, drive: 1'b0,
    wrByte: 8'h00, wrSeen: 1'b0
  };

  hsms_sys_type sys_q;
  hsms_sys_type sys_d;
  hsms_link_type link_q;
  hsms_link_type link_d;
  logic sdaOe_q;

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  // lowest enabled channel at or above index from; {found, channel}
  function automatic logic [2:0] hsms_pick(
    input logic [2:0] from,
    input logic [7:0] cfg
  );
    logic [2:0] res;
    logic en;
    res = 3'h0;
    for (int i = 3; i >= 0; i--) begin
      en = (i == 3) ? cfg[hsms_pkg::CFG_TEMP_BIT]
                    : cfg[hsms_pkg::CFG_FIELD_BIT];
      if (en && (3'(i) >= from)) begin
        res = {1'b1, 2'(i)};
      end
    end
    return res;
  endfunction

  // read byte order: high parts, then packed low parts
  function automatic logic [7:0] hsms_byte(
    input hsms_pkg::hsms_res_type r,
    input logic [2:0] idx
  );
    logic [7:0] b;
    case (idx)
      3'h0: b = r.x[11:4];
      3'h1: b = r.y[11:4];
      3'h2: b = r.z[11:4];
      3'h3: b = r.t[9:2];
      3'h4: b = {r.x[3:0], r.y[3:0]};
      default: b = {r.z[3:0], r.t[1:0], 2'h0};
    endcase
    return b;
  endfunction

  // ----------------------------------------------------------
  // link side: serial slave on the serial clock
  // ----------------------------------------------------------
  always_comb begin
    logic [7:0] nb;
    logic [7:0] nt;
    nb = {link_q.shift[6:0], sdaIn};
    nt = 8'h00;
    link_d = link_q;
    link_d.drive = 1'b0;
    if (link_q.bitCnt != hsms_pkg::ACK_BIT) begin
      link_d.shift = nb;
      link_d.bitCnt = link_q.bitCnt + 4'h1;
      if (link_q.bitCnt == hsms_pkg::LAST_DATA_BIT) begin
        case (link_q.phase)
          hsms_pkg::LK_ADDR: begin
            if (nb == hsms_pkg::ADDR_WR) begin // R09
              link_d.phase = hsms_pkg::LK_WRITE;
              link_d.drive = 1'b1;
            end else if (nb == hsms_pkg::ADDR_RD) begin // R09
              link_d.phase = hsms_pkg::LK_READ;
              link_d.drive = 1'b1;
            end else begin
              link_d.phase = hsms_pkg::LK_IGN;
            end
          end
          hsms_pkg::LK_WRITE: begin
            link_d.wrByte = nb;
            link_d.wrSeen = 1'b1; // R12
            link_d.drive = 1'b1;
          end
          default: begin
            link_d.drive = 1'b0;
          end
        endcase
      end else if (link_q.phase == hsms_pkg::LK_READ) begin
        link_d.tx = {link_q.tx[6:0], 1'b0};
        link_d.drive = ~link_q.tx[6];
      end
    end else begin
      link_d.bitCnt = 4'h0;
      if (link_q.phase == hsms_pkg::LK_READ) begin
        if (!sdaIn) begin
          nt = hsms_byte(sys_q.shown, link_q.byteIdx); // R17
          link_d.tx = nt;
          link_d.drive = ~nt[7];
          link_d.byteIdx = (link_q.byteIdx == hsms_pkg::RD_LAST)
                           ? 3'h0 : link_q.byteIdx + 3'h1;
        end else begin
          link_d.phase = hsms_pkg::LK_IGN;
        end
      end
    end
  end

  // frame end or repeated start clears the link logic
  always_ff @(posedge sclClk or posedge sys_q.frameRst) begin
    if (sys_q.frameRst) begin
      link_q <= LINK_RST;
    end else begin
      link_q <= link_d; // R01
    end
  end

  // data line changes only while the serial clock is low
  always_ff @(negedge sclClk or posedge sys_q.frameRst) begin
    if (sys_q.frameRst) begin
      sdaOe_q <= 1'b0;
    end else begin
      sdaOe_q <= link_q.drive; // R10
    end
  end

  // ----------------------------------------------------------
  // system side: pins, sequencer, results, interrupt
  // ----------------------------------------------------------
  always_comb begin
    logic start;
    logic stop;
    logic [2:0] pick;
    start = 1'b0;
    stop = 1'b0;
    pick = 3'h0;
    sys_d = sys_q;
    sys_d.sclS = {sys_q.sclS[1:0], sclClk};
    sys_d.sdaS = {sys_q.sdaS[1:0], sdaIn};
    sys_d.supS = {sys_q.supS[1:0], supplyOk};
    if (sys_q.sclS[1] == sys_q.sclS[2]) begin
      sys_d.sclF = sys_q.sclS[2];
    end
    if (sys_q.sdaS[1] == sys_q.sdaS[2]) begin
      sys_d.sdaF = sys_q.sdaS[2];
    end
    if (sys_q.supS[1] == sys_q.supS[2]) begin
      sys_d.supF = sys_q.supS[2];
    end
    start = sys_q.sclF && sys_d.sclF && sys_q.sdaF && !sys_d.sdaF;
    stop = sys_q.sclF && sys_d.sclF && !sys_q.sdaF && sys_d.sdaF;
    pick = 3'h0;
    sys_d.adcGo = 1'b0;

    // sequencer
    case (sys_q.seq)
      hsms_pkg::SQ_POR: begin
        if (sys_q.cnt == 8'h00) begin
          sys_d.seq = hsms_pkg::SQ_LOWPWR; // R13
        end else begin
          sys_d.cnt = sys_q.cnt - 8'h01;
        end
      end
      hsms_pkg::SQ_LOWPWR: begin
        if (sys_q.req) begin
          sys_d.req = 1'b0;
          sys_d.seq = hsms_pkg::SQ_BIAS; // R03
          sys_d.cnt = hsms_pkg::BIAS_LOAD;
        end
      end
      hsms_pkg::SQ_BIAS: begin
        if (sys_q.cnt == 8'h00) begin
          sys_d.seq = hsms_pkg::SQ_RESCHK;
        end else begin
          sys_d.cnt = sys_q.cnt - 8'h01;
        end
      end
      hsms_pkg::SQ_RESCHK: begin
        sys_d.seq = sys_q.supF ? hsms_pkg::SQ_OSC
                               : hsms_pkg::SQ_HALT; // R03
        sys_d.cnt = hsms_pkg::OSC_LOAD;
      end
      hsms_pkg::SQ_OSC: begin
        if (sys_q.cnt == 8'h00) begin
          sys_d.seq = hsms_pkg::SQ_HALL;
          sys_d.cnt = hsms_pkg::HALL_LOAD;
        end else begin
          sys_d.cnt = sys_q.cnt - 8'h01;
        end
      end
      hsms_pkg::SQ_HALL: begin
        if (sys_q.cnt != 8'h00) begin
          sys_d.cnt = sys_q.cnt - 8'h01;
        end else begin
          pick = hsms_pick(3'h0, sys_q.cfg); // R04
          if (pick[2]) begin
            sys_d.seq = hsms_pkg::SQ_CONV;
            sys_d.ch = pick[1:0];
            sys_d.adcGo = 1'b1;
          end else begin
            sys_d.seq = hsms_pkg::SQ_DONE;
          end
        end
      end
      hsms_pkg::SQ_CONV: begin
        if (adcDone) begin
          case (sys_q.ch)
            hsms_pkg::CH_X: sys_d.work.x = adcData; // R11
            hsms_pkg::CH_Y: sys_d.work.y = adcData;
            hsms_pkg::CH_Z: sys_d.work.z = adcData;
            default: sys_d.work.t = adcData[11:2];
          endcase
          pick = hsms_pick({1'b0, sys_q.ch} + 3'h1, sys_q.cfg); // R05
          if (pick[2]) begin
            sys_d.ch = pick[1:0];
            sys_d.adcGo = 1'b1;
          end else begin
            sys_d.seq = hsms_pkg::SQ_DONE;
          end
        end
      end
      hsms_pkg::SQ_DONE: begin
        sys_d.latest = sys_q.work;
        sys_d.intOe = 1'b1; // R08
        sys_d.intCnt = hsms_pkg::INT_LOAD;
        if (sys_q.cfg[hsms_pkg::CFG_CONT_BIT]) begin
          sys_d.seq = hsms_pkg::SQ_BIAS;
          sys_d.cnt = hsms_pkg::BIAS_LOAD;
        end else begin
          sys_d.seq = hsms_pkg::SQ_LOWPWR; // R02
        end
      end
      hsms_pkg::SQ_HALT: begin
        if (sys_q.supF) begin
          sys_d.seq = hsms_pkg::SQ_BIAS; // R06
          sys_d.cnt = hsms_pkg::BIAS_LOAD;
        end
      end
      default: begin
        sys_d.seq = hsms_pkg::SQ_LOWPWR;
      end
    endcase

    // low supply abandons any running step from bias through conversion; power-on and done run on
    if (!sys_q.supF && (sys_q.seq inside {hsms_pkg::SQ_BIAS,
        hsms_pkg::SQ_RESCHK, hsms_pkg::SQ_OSC, hsms_pkg::SQ_HALL,
        hsms_pkg::SQ_CONV})) begin
      sys_d.seq = hsms_pkg::SQ_HALT; // R07
      sys_d.adcGo = 1'b0;
    end

    // supply outputs follow the next state
    sys_d.biasEn = sys_d.seq inside {hsms_pkg::SQ_POR,
      hsms_pkg::SQ_BIAS, hsms_pkg::SQ_RESCHK, hsms_pkg::SQ_OSC,
      hsms_pkg::SQ_HALL, hsms_pkg::SQ_CONV};
    sys_d.oscEn = sys_d.seq inside {hsms_pkg::SQ_POR,
      hsms_pkg::SQ_OSC, hsms_pkg::SQ_HALL, hsms_pkg::SQ_CONV};
    sys_d.hallEn = sys_d.seq inside {hsms_pkg::SQ_HALL,
      hsms_pkg::SQ_CONV};

    // interrupt pulse width
    if (sys_q.intOe && sys_q.seq != hsms_pkg::SQ_DONE) begin
      if (sys_q.intCnt == 8'h00) begin
        sys_d.intOe = 1'b0; // R16
      end else begin
        sys_d.intCnt = sys_q.intCnt - 8'h01;
      end
    end

    // read copy refreshed only while the bus is idle
    if (sys_q.pending && sys_q.frameRst) begin
      sys_d.shown = sys_q.latest; // R17
      sys_d.pending = 1'b0;
    end
    if (sys_q.seq == hsms_pkg::SQ_DONE) begin
      sys_d.pending = 1'b1;
    end

    // frame boundaries; link state is static while the clock is high
    if (sys_q.armRel) begin
      sys_d.frameRst = 1'b0;
      sys_d.armRel = 1'b0;
    end
    if (start || stop) begin
      sys_d.frameRst = 1'b1;
      sys_d.armRel = start;
      if (!sys_q.frameRst && link_q.wrSeen) begin
        sys_d.cfg = link_q.wrByte;
        sys_d.req = 1'b1; // R12
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sys_q <= SYS_RST;
    end else begin
      sys_q <= sys_d;
    end
  end

  // ----------------------------------------------------------
  // outputs
  // ----------------------------------------------------------
  assign sdaOut = sys_q.sdaOut;
  assign sdaOe = sdaOe_q;
  assign intOe = sys_q.intOe;
  assign biasEn = sys_q.biasEn;
  assign fastOscEn = sys_q.oscEn;
  assign hallBiasEn = sys_q.hallEn;
  assign muxSel = sys_q.ch;
  assign adcStart = sys_q.adcGo;

endmodule

// ==== sim/hsms_checker.sv ====
// assertions on the sequencer top ports
// assumes binding onto hsms_top, properties on the system clock
module hsms_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic sclClk,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic intOe,
  input wire logic supplyOk,
  input wire logic [11:0] adcData,
  input wire logic adcDone,
  input wire logic biasEn,
  input wire logic fastOscEn,
  input wire logic hallBiasEn,
  input wire logic [1:0] muxSel,
  input wire logic adcStart
);
  // ----
  // interrupt width counter
  // ----
  logic [7:0] intCnt;
  always_ff @(posedge clock) begin
    if (rst) intCnt <= 8'h00;
    else if (intOe) intCnt <= intCnt + 8'h01;
    else intCnt <= 8'h00;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence por_on;
    (biasEn && fastOscEn)[*8];
  endsequence
  sequence supply_lost;
    (!supplyOk)[*6];
  endsequence
  // ----
  // properties
  // ----
  a_data_low: assert property (!sdaOut)
    else $error("data output not zero");
  a_sda_negedge: assert property ($changed(sdaOe) |-> !sclClk)
    else $error("data drive changed with serial clock high");
  a_por_enables: assert property ($fell(rst) |-> por_on)
    else $error("power-on enables missing");
  a_start_pulse: assert property (adcStart |=> !adcStart)
    else $error("converter start longer than one cycle");
  a_start_biased: assert property (
    adcStart |-> biasEn && fastOscEn && hallBiasEn)
    else $error("conversion without bias or oscillator");
  a_hall_after_osc: assert property (
    $rose(hallBiasEn) |-> fastOscEn && $past(fastOscEn, 8))
    else $error("hall bias before oscillator ran");
  a_mux_hold: assert property (
    $changed(muxSel) && hallBiasEn |-> adcStart)
    else $error("channel moved without a start");
  a_int_width: assert property (
    $fell(intOe) |-> intCnt == 8'(hsms_pkg::INT_CYC))
    else $error("interrupt pulse width wrong");
  a_int_no_conv: assert property (
    intOe |-> !adcStart && !hallBiasEn)
    else $error("interrupt during conversion");
  a_halt_drop: assert property (
    supply_lost |-> !biasEn && !fastOscEn && !hallBiasEn)
    else $error("enables held with supply low");
endmodule

// ==== sim/hsms_host.sv ====
// bus master model facing the sequencer's serial slave
// assumes a pull-up on the data line, wired level fed back on sdaLine
module hsms_host (
  output logic sclClk,
  output logic sdaLow,
  input wire logic sdaLine
);
  timeunit 1ns;
  timeprecision 100ps;
  // clock only runs inside frames, high when idle
  initial begin
    sclClk = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic start;
    sdaLow = 1'b0;
    #40 sclClk = 1'b1;
    #80 sdaLow = 1'b1;
    #240 sclClk = 1'b0;
    #40;
  endtask
  task automatic bitOut(input logic b);
    sdaLow = ~b;
    #40 sclClk = 1'b1;
    #80 sclClk = 1'b0;
    #40;
  endtask
  task automatic bitIn(output logic b);
    sdaLow = 1'b0;
    #40 b = sdaLine;
    sclClk = 1'b1;
    #80 sclClk = 1'b0;
    #40;
  endtask
  task automatic sendByte(input logic [7:0] v, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bitOut(v[i]);
    bitIn(a);
    ack = ~a;
  endtask
  task automatic recvByte(input logic last, output logic [7:0] v);
    for (int i = 7; i >= 0; i--) bitIn(v[i]);
    bitOut(last);
  endtask
  task automatic stop;
    sdaLow = 1'b1;
    #40 sclClk = 1'b1;
    #80 sdaLow = 1'b0;
    #160;
  endtask
endmodule

// ==== sim/hsms_top_tb.sv ====
// self-checking bench for the sequencer top
// assumes hsms_host as bus master and a simple converter model here
module hsms_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, rst, sclClk, sdaIn, sdaOut, sdaOe, intOe, supplyOk;
  logic adcDone, biasEn, fastOscEn, hallBiasEn, adcStart, sdaLow;
  logic [11:0] adcData;
  logic [1:0] muxSel, curCh;
  logic [3:0] gen;
  logic [11:0] base [4], res [4];
  logic [1:0] chanLog [$];
  int num_errors, num_checks, adcWait, pulses;
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  assign sdaIn = ~((sdaOe & ~sdaOut) | sdaLow);
  hsms_top dut_u (.clock(clock), .rst(rst), .sclClk(sclClk),
    .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .intOe(intOe),
    .supplyOk(supplyOk), .adcData(adcData), .adcDone(adcDone),
    .biasEn(biasEn), .fastOscEn(fastOscEn), .hallBiasEn(hallBiasEn),
    .muxSel(muxSel), .adcStart(adcStart));
  hsms_host host_u (.sclClk(sclClk), .sdaLow(sdaLow), .sdaLine(sdaIn));
  // ----
  // converter model and interrupt watch
  // ----
  always @(negedge clock) begin
    if (adcStart === 1'b1) begin
      chanLog.push_back(muxSel);
      curCh = muxSel;
      adcWait = 4;
    end else if (adcWait != 0) adcWait = adcWait - 1;
    if (adcWait == 1) begin
      adcData = base[curCh] + {8'h00, gen};
      res[curCh] = adcData;
    end
    adcDone = (adcWait == 1);
  end
  always @(posedge intOe) pulses = pulses + 1;
  // ----
  // helpers
  // ----
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic trigger(input logic [7:0] cfg);
    logic a;
    chanLog.delete();
    gen = gen + 4'h1;
    host_u.start();
    host_u.sendByte(hsms_pkg::ADDR_WR, a);
    check(16'(a), 16'h0001);
    host_u.sendByte(cfg, a);
    check(16'(a), 16'h0001);
    host_u.stop();
  endtask
  task automatic finishRun(input logic [7:0] cfg);
    logic a;
    logic [7:0] b;
    logic [7:0] exp [6];
    logic [1:0] want [$];
    int n;
    n = 0;
    while (intOe !== 1'b1 && n < 2000) begin
      @(negedge clock);
      n++;
    end
    check(16'(intOe), 16'h0001);
    n = 0;
    while (intOe === 1'b1 && n < 200) begin
      @(negedge clock);
      n++;
    end
    check(16'(n), 16'(hsms_pkg::INT_CYC));
    for (int i = 0; i < 4; i++) if (i < 3 ? cfg[1] : cfg[0]) want.push_back(2'(i));
    check(16'(chanLog.size()), 16'(want.size()));
    foreach (want[i]) check(16'(chanLog[i]), 16'(want[i]));
    exp = '{res[0][11:4], res[1][11:4], res[2][11:4], res[3][11:4],
      {res[0][3:0], res[1][3:0]}, {res[2][3:0], res[3][3:2], 2'b00}};
    host_u.start();
    host_u.sendByte(hsms_pkg::ADDR_RD, a);
    check(16'(a), 16'h0001);
    for (int i = 0; i < 6; i++) begin
      host_u.recvByte(i == 5, b);
      check(16'(b), 16'(exp[i]));
    end
    host_u.stop();
  endtask
  // ----
  // scenarios
  // ----
  task automatic test_startup;
    check(16'({biasEn, fastOscEn}), 16'h0003);
    repeat (hsms_pkg::POR_CYC + 10) @(negedge clock);
    check(16'({biasEn, fastOscEn, hallBiasEn, intOe}), 16'h0000);
    host_u.start();
    host_u.stop();
  endtask
  task automatic test_badaddr;
    logic a;
    int p;
    p = pulses;
    host_u.start();
    host_u.sendByte(8'h6C, a);
    check(16'(a), 16'h0000);
    host_u.sendByte(8'h03, a);
    check(16'(a), 16'h0000);
    host_u.stop();
    repeat (400) @(negedge clock);
    check(16'(pulses), 16'(p));
    check(16'({biasEn, sdaOe}), 16'h0000);
  endtask
  task automatic test_halt;
    int n;
    trigger(8'h03);
    n = 0;
    while (hallBiasEn !== 1'b1 && n < 1000) begin
      @(negedge clock);
      n++;
    end
    repeat (5) @(negedge clock);
    supplyOk = 1'b0;
    repeat (10) @(negedge clock);
    check(16'({biasEn, fastOscEn, hallBiasEn}), 16'h0000);
    check(16'(chanLog.size()), 16'h0000);
    supplyOk = 1'b1;
    finishRun(8'h03);
  endtask
  task automatic test_cont;
    int n;
    trigger(8'h04);
    n = 0;
    while (intOe !== 1'b1 && n < 2000) begin
      @(negedge clock);
      n++;
    end
    repeat (5) @(negedge clock);
    check(16'({biasEn, intOe}), 16'h0003);
    trigger(8'h00);
    repeat (800) @(negedge clock);
    check(16'({biasEn, fastOscEn, intOe}), 16'h0000);
  endtask
  initial begin
    rst = 1'b1;
    supplyOk = 1'b1;
    adcData = 12'h000;
    adcDone = 1'b0;
    gen = 4'h0;
    base = '{12'hA5C, 12'h3B1, 12'h7E2, 12'hC94};
    repeat (6) @(negedge clock);
    rst = 1'b0;
    test_startup();
    test_badaddr();
    foreach (base[i]) begin
      trigger(8'h03 >> i);
      finishRun(8'h03 >> i);
    end
    test_halt();
    test_cont();
    results();
  end
  initial begin
    #400000;
    num_errors++;
    $display("BAD %0t watchdog expired", $time);
    results();
  end
endmodule
bind hsms_top hsms_checker chk_u (.clock(clock), .rst(rst),
  .sclClk(sclClk), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .intOe(intOe), .supplyOk(supplyOk), .adcData(adcData),
  .adcDone(adcDone), .biasEn(biasEn), .fastOscEn(fastOscEn),
  .hallBiasEn(hallBiasEn), .muxSel(muxSel), .adcStart(adcStart));
